// >>> bench/address_breakpoint_unit_assertions.sv
// port-level assertions for the breakpoint unit
`timescale 1ns/1ps
`default_nettype none
`include "brk_defs.svh"
module address_breakpoint_unit_assertions
   import brk_pkg::*;
#(
   parameter int ADDR_W = 18
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic monitorMode,
   input wire logic returnFromInterrupt,
   input wire trapReq_s trapReq,
   input wire breakEffects_s breakEffects
);
   logic inBrk;
   logic trap;
   // short names for the break state and the trap pulse
   assign inBrk = breakEffects.breakState;
   assign trap = trapReq.trapLoad;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // vector register follows the mode one cycle late
   property vecSel;
      clkEn |=> trapReq.trapVector ==
         ($past(monitorMode) ? `BRK_VECTOR_MONITOR : `BRK_VECTOR_NORMAL);
   endproperty
   a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer not held");
   a_read_answer: assert property (arvalid && arready && clkEn |=> rvalid)
      else $error("read answer late");
   a_trap_enters: assert property (trap && clkEn |=> inBrk && breakEffects.timerStop)
      else $error("trap did not enter break state");
   a_break_stays: assert property (inBrk && !returnFromInterrupt
      |=> inBrk && breakEffects.captureInhibit)
      else $error("break state left early");
   a_rti_ends: assert property (inBrk && returnFromInterrupt && !trap && clkEn |=> !inBrk)
      else $error("return did not end break state");
   a_no_retrap: assert property (inBrk |-> !trap)
      else $error("trap taken inside break state");
   a_trap_has_req: assert property (trap |-> trapReq.breakpointRequest)
      else $error("trap without request");
   a_vector_sel: assert property (vecSel)
      else $error("wrong trap vector");
   a_watchdog_gate: assert property (breakEffects.watchdogDisable |-> inBrk)
      else $error("watchdog off outside break");
   a_flag_clear: assert property (!inBrk |-> breakEffects.flagClearAllowed)
      else $error("flag clearing blocked outside break");
   c_sw_trap: cover property (trap && monitorMode);
   c_slverr: cover property (bvalid && bresp == `BRK_RESP_SLVERR);
   c_watchdog: cover property (breakEffects.watchdogDisable);
endmodule : address_breakpoint_unit_assertions
bind address_breakpoint_unit address_breakpoint_unit_assertions #(.ADDR_W(ADDR_W)) chk (
   .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .arvalid(arvalid), .arready(arready),
   .rvalid(rvalid), .bresp(bresp), .bvalid(bvalid), .bready(bready), .monitorMode(monitorMode),
   .returnFromInterrupt(returnFromInterrupt), .trapReq(trapReq), .breakEffects(breakEffects));
`default_nettype wire

// >>> bench/address_breakpoint_unit_tb.sv
// self-checking bench for the address breakpoint unit
`timescale 1ns/1ps
`default_nettype none
`include "brk_defs.svh"
module address_breakpoint_unit_tb
   import brk_pkg::*;
();
   localparam logic [17:0] A_ST = {`BRK_IDX_STATUS, 2'h0};
   localparam logic [17:0] A_FC = {`BRK_IDX_FLAG_CTRL, 2'h0};
   localparam logic [17:0] A_AH = {`BRK_IDX_ADDR_HIGH, 2'h0};
   localparam logic [17:0] A_AL = {`BRK_IDX_ADDR_LOW, 2'h0};
   localparam logic [17:0] A_SC = {`BRK_IDX_STATUS_CTRL, 2'h0};
   typedef struct packed {
      logic [17:0] a;
      logic [7:0] d;
      logic [7:0] e;
      logic [1:0] r;
   } row_s;
   logic sys_clk = 1'h0, arst_n = 1'h0, clkEn = 1'h1;
   logic [17:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = '0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, trapBnd, trapRq, returnFromInterrupt;
   logic [1:0] bresp, rresp;
   logic lowPowerMode = 1'h0, waitMode = 1'h0, monitorMode = 1'h0, testHighVoltagePin = 1'h0;
   logic run = 1'h0, retGo = 1'h0;
   logic [15:0] startAddr = 16'h0000, trapAddr;
   cpuBus_s cpuBus;
   trapReq_s trapReq;
   breakEffects_s breakEffects;
   int failures = 0, n_tests = 0, trapCnt = 0, n0;
   row_s rows [0:7] = '{'{A_AH, 8'hA5, 8'hA5, 2'h0}, '{A_AL, 8'h3C, 8'h3C, 2'h0},
      '{A_FC, 8'hFF, 8'h80, 2'h0}, '{A_FC, 8'h7F, 8'h00, 2'h0}, '{A_SC, 8'h80, 8'h80, 2'h0},
      '{A_SC, 8'h3F, 8'h00, 2'h0}, '{A_ST, 8'hFF, 8'h00, 2'h0},
      '{{16'hFE01, 2'h0}, 8'h55, 8'h00, `BRK_RESP_SLVERR}};
   initial forever #12.5 sys_clk = ~sys_clk;
   address_breakpoint_unit #(.ADDR_W(18)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
      .clkEn(clkEn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .cpuBus(cpuBus),
      .returnFromInterrupt(returnFromInterrupt), .lowPowerMode(lowPowerMode),
      .waitMode(waitMode), .monitorMode(monitorMode), .testHighVoltagePin(testHighVoltagePin),
      .trapReq(trapReq), .breakEffects(breakEffects));
   cpu_model cpu (.sys_clk(sys_clk), .arst_n(arst_n), .run(run), .startAddr(startAddr),
      .retGo(retGo), .trapLoad(trapReq.trapLoad), .cpuBus(cpuBus),
      .returnFromInterrupt(returnFromInterrupt));
   // records every trap with the bus cycle that took it
   always @(posedge sys_clk)
      if (trapReq.trapLoad === 1'h1)
      begin
         trapCnt++;
         trapAddr = cpuBus.addr;
         trapBnd = cpuBus.instrBoundary;
         trapRq = trapReq.breakpointRequest;
      end
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   // a used-up wait counts as a mismatch and ends the run
   task automatic tmo(input int n);
      if (n >= 60)
      begin
         failures++;
         results();
      end
   endtask : tmo
   task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge sys_clk);
         n++;
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end
      while (bvalid !== 1'h1 && n < 60);
      bready <= 1'h0;
      tmo(n);
      chk({30'h0, bresp}, {30'h0, er});
      tick(1);
   endtask : wr
   task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge sys_clk);
         n++;
         if (arready)
            arvalid <= 1'h0;
      end
      while (rvalid !== 1'h1 && n < 60);
      rready <= 1'h0;
      tmo(n);
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
      tick(1);
   endtask : rd
   task automatic regZero;
      rd(A_ST, 32'h0);
      rd(A_FC, 32'h0);
      rd(A_AH, 32'h0);
      rd(A_AL, 32'h0);
      rd(A_SC, 32'h0);
   endtask : regZero
   // restart the cpu model at a new address
   task automatic go(input logic [15:0] s);
      run <= 1'h0;
      startAddr <= s;
      tick(1);
      run <= 1'h1;
   endtask : go
   task automatic waitTrap;
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      while (trapCnt == n0 && n < 60);
      @(posedge sys_clk);
      tmo(n);
   endtask : waitTrap
   task automatic ret;
      retGo <= 1'h1;
      tick(1);
      retGo <= 1'h0;
      tick(3);
      chk(breakEffects.breakState, 1'h0);
   endtask : ret
   task automatic quiet(input logic [15:0] s);
      n0 = trapCnt;
      go(s);
      tick(12);
      run <= 1'h0;
      chk(trapCnt, n0);
   endtask : quiet
   initial
   begin
      tick(16);
      arst_n <= 1'h1;
      tick(1);
      regZero();
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d, rows[i].r);
         rd(rows[i].a, {24'h0, rows[i].e}, rows[i].r);
      end
      $display("register table done");
      // opcode match: trap in the fetch cycle, no second trap on return
      wr(A_AH, 8'h12);
      wr(A_AL, 8'h34);
      wr(A_SC, 8'h80);
      n0 = trapCnt;
      go(16'h1230);
      waitTrap();
      chk(trapAddr, 16'h1234);
      chk(trapRq, 1'h1);
      chk(trapReq.trapVector, `BRK_VECTOR_NORMAL);
      chk(breakEffects, 5'h1C);
      rd(A_SC, 32'hC0);
      wr(A_SC, 8'h80);
      rd(A_SC, 32'h80);
      n0 = trapCnt;
      ret();
      tick(10);
      chk(trapCnt, n0);
      run <= 1'h0;
      $display("opcode match done");
      // operand match: instruction completes first
      wr(A_AL, 8'h41);
      wr(A_FC, 8'h80);
      n0 = trapCnt;
      go(16'h1240);
      waitTrap();
      chk(trapAddr, 16'h1241);
      chk(trapRq, 1'h1);
      chk(breakEffects, 5'h1D);
      wr(A_SC, 8'h80);
      ret();
      run <= 1'h0;
      $display("operand match done");
      // software trap in monitor mode, waking from wait
      wr(A_SC, 8'h00);
      monitorMode <= 1'h1;
      waitMode <= 1'h1;
      testHighVoltagePin <= 1'h1;
      go(16'h2000);
      tick(8);
      n0 = trapCnt;
      wr(A_SC, 8'h40);
      waitTrap();
      chk(trapBnd, 1'h1);
      chk(trapReq.trapVector, `BRK_VECTOR_MONITOR);
      chk(breakEffects.watchdogDisable, 1'h1);
      rd(A_ST, 32'h02);
      wr(A_ST, 8'h00);
      rd(A_ST, 32'h00);
      wr(A_SC, 8'h00);
      ret();
      monitorMode <= 1'h0;
      waitMode <= 1'h0;
      testHighVoltagePin <= 1'h0;
      $display("software trap done");
      // windows in which no trap may be taken, then a positive one
      wr(A_AL, 8'h48);
      wr(A_AH, 8'h13);
      wr(A_SC, 8'h80);
      quiet(16'h1244);
      wr(A_AH, 8'h12);
      lowPowerMode <= 1'h1;
      quiet(16'h1244);
      lowPowerMode <= 1'h0;
      wr(A_SC, 8'h00);
      quiet(16'h1244);
      wr(A_SC, 8'h80);
      n0 = trapCnt;
      go(16'h1244);
      waitTrap();
      chk(trapAddr, 16'h1248);
      // reset in the middle of a break
      arst_n <= 1'h0;
      run <= 1'h0;
      tick(2);
      arst_n <= 1'h1;
      tick(1);
      chk(breakEffects.breakState, 1'h0);
      regZero();
      $display("mid-run reset done");
      // clock enable low freezes the vector register, release lets it follow
      monitorMode <= 1'h1;
      clkEn <= 1'h0;
      tick(3);
      chk(trapReq.trapVector, `BRK_VECTOR_NORMAL);
      clkEn <= 1'h1;
      tick(3);
      chk(trapReq.trapVector, `BRK_VECTOR_MONITOR);
      monitorMode <= 1'h0;
      $display("clock enable done");
      results();
   end
endmodule : address_breakpoint_unit_tb
`default_nettype wire

// >>> bench/cpu_model.sv
// behavioural cpu core and system integration model
`timescale 1ns/1ps
`default_nettype none
module cpu_model
   import brk_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic run,
   input wire logic [15:0] startAddr,
   input wire logic retGo,
   input wire logic trapLoad,
   output cpuBus_s cpuBus,
   output logic returnFromInterrupt
);
   logic [15:0] pc_r;
   logic inBreak_r;
   logic live;
   // two-byte instructions: opcode on even, operand on odd addresses
   assign live = run & ~inBreak_r;
   assign cpuBus.addr = live ? pc_r : ~pc_r; // idle bus never repeats the last address
   assign cpuBus.valid = live;
   assign cpuBus.opcodeFetch = live & ~pc_r[0];
   assign cpuBus.instrBoundary = live & pc_r[0];
   // program counter, break routine and return
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pc_r <= 16'h0000;
         inBreak_r <= 1'h0;
         returnFromInterrupt <= 1'h0;
      end
      else
      begin
         returnFromInterrupt <= retGo & inBreak_r;
         if (trapLoad)
         begin
            inBreak_r <= 1'h1;
            pc_r <= pc_r + {15'h0, pc_r[0]};
         end
         else if (returnFromInterrupt)
            inBreak_r <= 1'h0;
         else if (!run)
            pc_r <= startAddr;
         else if (live)
            pc_r <= pc_r + 16'h0001;
      end
   end
endmodule : cpu_model
`default_nettype wire

// >>> core/address_breakpoint_unit.sv
// address breakpoint unit with its axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "brk_defs.svh"

// How it works
// - with match enable set, full 16-bit address bus compared to break address
// - a break loads the software trap and vectors to FFFC, or FEFC in monitor
// - an enabled address match sets the break active flag
// - software writing one to break active forces a break before next instruction
// - match on an opcode address holds that instruction until the routine ends
// - match on an operand address lets the instruction finish before the break
// - writing zero or reset clears break active; routine must clear it first
// - writing zero to bit 7 or any reset clears the match enable
// - unchanged break address after clearing active gives no break on return
// - break address high and low bytes live at FE09 and FE0A, reset to zero
// - flag-clear enable one lets flag clearing work in break state, resets zero
// - break state stops the timer counter and inhibits input captures
// - break state disables the activity watchdog when test voltage is present
// - wait-exit flag set when a break ends wait, cleared by writing zero
// - wait and stop keep the unit enabled but the idle bus triggers nothing
// - status control holds enable in bit 7, active in bit 6, zeros below
// - an address match raises the breakpoint request to system integration
// - the return-from-interrupt in the routine ends the break state
module address_breakpoint_unit
   import brk_pkg::*;
#(
   parameter int ADDR_W = 18
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   // axi4-lite slave
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // cpu side
   input wire cpuBus_s cpuBus,
   input wire logic returnFromInterrupt,
   input wire logic lowPowerMode,
   input wire logic waitMode,
   input wire logic monitorMode,
   input wire logic testHighVoltagePin,
   // towards system integration logic and peripherals
   output trapReq_s trapReq,
   output breakEffects_s breakEffects
);

   // register state
   logic [15:0] breakAddr_r;
   logic matchEnable_r;
   logic breakActive_r;
   logic flagClearEnable_r;
   logic waitExit_r;
   logic pending_r;
   logic breakState_r;
   logic rearmBlock_r;
   logic [15:0] trapVector_r;

   // bus state
   logic [ADDR_W-1:0] wrAddr_r;
   logic [7:0] wrData_r;
   logic wrStrobe_r;
   logic haveAddr_r;
   logic haveData_r;
   logic [31:0] rdData_r;
   logic [1:0] rdResp_r;
   logic [1:0] wrResp_r;
   logic bvalid_r;
   logic rvalid_r;

   logic testHighVoltage;
   logic matchNow;
   logic takeNow;
   logic wrFire;
   logic wrOk;
   regSel_e wrSel;
   regSel_e rdSel;
   logic [7:0] statusCtrlRd;

   // test voltage arrives on a pin and is synchronised
   pin_sync u_tst_sync
   (
      .sys_clk (sys_clk),
      .arst_n (arst_n),
      .clkEn (clkEn),
      .pinIn (testHighVoltagePin),
      .pinOut (testHighVoltage)
   );

   // address to register decode, index is byte address over four
   function automatic regSel_e decodeReg(input logic [ADDR_W-1:0] a);
      logic [15:0] idx;
      idx = 16'(a[ADDR_W-1:2]);
      if (a[1:0] != 2'h0)
         decodeReg = REG_NONE;
      else if (idx == `BRK_IDX_STATUS)
         decodeReg = REG_STATUS;
      else if (idx == `BRK_IDX_FLAG_CTRL)
         decodeReg = REG_FLAG_CTRL;
      else if (idx == `BRK_IDX_ADDR_HIGH)
         decodeReg = REG_ADDR_HIGH;
      else if (idx == `BRK_IDX_ADDR_LOW)
         decodeReg = REG_ADDR_LOW;
      else if (idx == `BRK_IDX_STATUS_CTRL)
         decodeReg = REG_STATUS_CTRL;
      else
         decodeReg = REG_NONE;
   endfunction : decodeReg

   // comparator: valid cycle, enabled, idle bus in low power never matches
   assign matchNow = matchEnable_r && cpuBus.valid && !lowPowerMode
      && !rearmBlock_r && !breakState_r && (cpuBus.addr == breakAddr_r);

   // opcode match traps at once, operand match or forced break at the boundary
   assign takeNow = !breakState_r && ((matchNow && cpuBus.opcodeFetch)
      || ((pending_r || matchNow) && cpuBus.instrBoundary));

   // trap request
   assign trapReq.breakpointRequest = matchNow || pending_r;
   assign trapReq.trapLoad = takeNow;
   assign trapReq.trapVector = trapVector_r;

   // effects of the break state on the rest of the chip
   assign breakEffects.breakState = breakState_r;
   assign breakEffects.timerStop = breakState_r;
   assign breakEffects.captureInhibit = breakState_r;
   assign breakEffects.watchdogDisable = breakState_r && testHighVoltage;
   assign breakEffects.flagClearAllowed = !breakState_r || flagClearEnable_r;

   // trap vector follows the operating mode
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         trapVector_r <= `BRK_VECTOR_NORMAL;
      else if (clkEn)
         trapVector_r <= monitorMode ? `BRK_VECTOR_MONITOR : `BRK_VECTOR_NORMAL;
   end

   // write channel: address and data taken in either order
   assign awready = !haveAddr_r && !bvalid_r;
   assign wready = !haveData_r && !bvalid_r;
   assign wrFire = haveAddr_r && haveData_r && !bvalid_r;
   assign wrSel = decodeReg(wrAddr_r);
   assign wrOk = wrFire && wrStrobe_r && (wrSel != REG_NONE);

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         haveAddr_r <= 1'b0;
         haveData_r <= 1'b0;
         wrAddr_r <= '0;
         wrData_r <= `BRK_REG8_RESET;
         wrStrobe_r <= 1'b0;
      end
      else if (clkEn)
      begin
         if (awvalid && awready)
         begin
            haveAddr_r <= 1'b1;
            wrAddr_r <= awaddr;
         end
         else if (wrFire)
            haveAddr_r <= 1'b0;
         if (wvalid && wready)
         begin
            haveData_r <= 1'b1;
            wrData_r <= wdata[7:0];
            wrStrobe_r <= wstrb[0];
         end
         else if (wrFire)
            haveData_r <= 1'b0;
      end
   end

   // write response, slave error for unmapped addresses
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bvalid_r <= 1'b0;
         wrResp_r <= `BRK_RESP_OKAY;
      end
      else if (clkEn)
      begin
         if (wrFire)
         begin
            bvalid_r <= 1'b1;
            wrResp_r <= (wrSel == REG_NONE) ? `BRK_RESP_SLVERR : `BRK_RESP_OKAY;
         end
         else if (bready)
            bvalid_r <= 1'b0;
      end
   end

   assign bvalid = bvalid_r;
   assign bresp = wrResp_r;

   // break address registers
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         breakAddr_r <= `BRK_ADDR_RESET;
      else if (clkEn && wrOk)
      begin
         if (wrSel == REG_ADDR_HIGH)
            breakAddr_r[15:8] <= wrData_r;
         else if (wrSel == REG_ADDR_LOW)
            breakAddr_r[7:0] <= wrData_r;
      end
   end

   // match enable, written through bit 7 of status control
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         matchEnable_r <= 1'b0;
      else if (clkEn && wrOk && wrSel == REG_STATUS_CTRL)
         matchEnable_r <= wrData_r[`BRK_SC_ENABLE_BIT];
   end

   // break active: a match wins over a software clear
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         breakActive_r <= 1'b0;
      else if (clkEn)
      begin
         if (matchNow)
            breakActive_r <= 1'b1;
         else if (wrOk && wrSel == REG_STATUS_CTRL)
            breakActive_r <= wrData_r[`BRK_SC_ACTIVE_BIT];
      end
   end

   // pending break waits for the next instruction boundary
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         pending_r <= 1'b0;
      else if (clkEn)
      begin
         if (wrOk && wrSel == REG_STATUS_CTRL && wrData_r[`BRK_SC_ACTIVE_BIT])
            pending_r <= 1'b1;
         else if (takeNow)
            pending_r <= 1'b0;
         else if (matchNow)
            pending_r <= 1'b1;
      end
   end

   // break state runs from the trap to the return from interrupt
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         breakState_r <= 1'b0;
      else if (clkEn)
      begin
         if (takeNow)
            breakState_r <= 1'b1;
         else if (returnFromInterrupt)
            breakState_r <= 1'b0;
      end
   end

   // the same address cannot trap again until software rewrites it
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         rearmBlock_r <= 1'b0;
      else if (clkEn)
      begin
         if (takeNow)
            rearmBlock_r <= 1'b1;
         else if (wrOk && (wrSel == REG_ADDR_HIGH || wrSel == REG_ADDR_LOW))
            rearmBlock_r <= 1'b0;
      end
   end

   // flag-clear enable in the flag control register
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         flagClearEnable_r <= 1'b0;
      else if (clkEn && wrOk && wrSel == REG_FLAG_CTRL)
         flagClearEnable_r <= wrData_r[`BRK_FC_CLEAR_EN_BIT];
   end

   // wait-exit flag: set by a trap out of wait, cleared by writing zero
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         waitExit_r <= 1'b0;
      else if (clkEn)
      begin
         if (takeNow && waitMode)
            waitExit_r <= 1'b1;
         else if (wrOk && wrSel == REG_STATUS && !wrData_r[`BRK_ST_WAIT_EXIT_BIT])
            waitExit_r <= 1'b0;
      end
   end

   // read channel, one cycle from address to data
   assign arready = !rvalid_r;
   assign rdSel = decodeReg(araddr);
   assign statusCtrlRd = {matchEnable_r, breakActive_r, 6'h00};

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rvalid_r <= 1'b0;
         rdData_r <= 32'h00000000;
         rdResp_r <= `BRK_RESP_OKAY;
      end
      else if (clkEn)
      begin
         if (arvalid && arready)
         begin
            rvalid_r <= 1'b1;
            rdResp_r <= `BRK_RESP_OKAY;
            if (rdSel == REG_STATUS)
               rdData_r <= {30'h00000000, waitExit_r, 1'b0};
            else if (rdSel == REG_FLAG_CTRL)
               rdData_r <= {24'h000000, flagClearEnable_r, 7'h00};
            else if (rdSel == REG_ADDR_HIGH)
               rdData_r <= {24'h000000, breakAddr_r[15:8]};
            else if (rdSel == REG_ADDR_LOW)
               rdData_r <= {24'h000000, breakAddr_r[7:0]};
            else if (rdSel == REG_STATUS_CTRL)
               rdData_r <= {24'h000000, statusCtrlRd};
            else
            begin
               rdData_r <= 32'h00000000;
               rdResp_r <= `BRK_RESP_SLVERR;
            end
         end
         else if (rready)
            rvalid_r <= 1'b0;
      end
   end

   assign rvalid = rvalid_r;
   assign rdata = rdData_r;
   assign rresp = rdResp_r;

endmodule : address_breakpoint_unit

`default_nettype wire

// >>> core/brk_defs.svh
// register map, field positions, reset values and trap constants of the breakpoint unit
`ifndef BRK_DEFS_SVH
`define BRK_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define BRK_IDX_STATUS 16'hFE00
`define BRK_IDX_FLAG_CTRL 16'hFE03
`define BRK_IDX_ADDR_HIGH 16'hFE09
`define BRK_IDX_ADDR_LOW 16'hFE0A
`define BRK_IDX_STATUS_CTRL 16'hFE0B

// field positions
`define BRK_SC_ENABLE_BIT 7
`define BRK_SC_ACTIVE_BIT 6
`define BRK_ST_WAIT_EXIT_BIT 1
`define BRK_FC_CLEAR_EN_BIT 7

// reset values
`define BRK_ADDR_RESET 16'h0000
`define BRK_REG8_RESET 8'h00

// trap vectors
`define BRK_VECTOR_NORMAL 16'hFFFC
`define BRK_VECTOR_MONITOR 16'hFEFC

// bus answers
`define BRK_RESP_OKAY 2'h0
`define BRK_RESP_SLVERR 2'h2

`endif

// >>> core/brk_pkg.sv
// types shared by the breakpoint unit
package brk_pkg;

   // one cpu bus cycle as seen by the comparator
   typedef struct packed {
      logic [15:0] addr;
      logic valid;
      logic opcodeFetch;
      logic instrBoundary;
   } cpuBus_s;

   // trap request towards the system integration logic
   typedef struct packed {
      logic breakpointRequest;
      logic trapLoad;
      logic [15:0] trapVector;
   } trapReq_s;

   // slices of the chip that react to the break state
   typedef struct packed {
      logic breakState;
      logic timerStop;
      logic captureInhibit;
      logic watchdogDisable;
      logic flagClearAllowed;
   } breakEffects_s;

   // register decoded from a bus address
   typedef enum logic [2:0] {
      REG_NONE,
      REG_STATUS,
      REG_FLAG_CTRL,
      REG_ADDR_HIGH,
      REG_ADDR_LOW,
      REG_STATUS_CTRL
   } regSel_e;

endpackage : brk_pkg

// >>> core/pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic pinIn,
   output logic pinOut
);

   logic stage1_r;
   logic stage2_r;
   logic stage3_r;

   // shift chain; the first stage feeds only the second
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage1_r <= 1'b0;
         stage2_r <= 1'b0;
         stage3_r <= 1'b0;
      end
      else if (clkEn)
      begin
         stage1_r <= pinIn;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
      end
   end

   // output moves only when the last two stages agree
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         pinOut <= 1'b0;
      else if (clkEn && (stage2_r == stage3_r))
         pinOut <= stage3_r;
   end

endmodule : pin_sync

`default_nettype wire
